// ==== rtl/mtseq_core.sv ====
// Measurement trigger sequencer: idle, event detection, delay, device action, output trigger.
// Function
// [R01] Continuous unscanned mode falls straight through idle.
// [R02] One-shot leaves idle on key, returns after.
// [R03] Scan end idles until halt command.
// [R04] Immediate source satisfies event detection at once.
// [R05] External source: trigger line, key, bus trigger.
// [R06] Trigger key ignored while under remote control.
// [R07] Programmable delay, auto or manual, before action.
// [R08] Auto delay from table for External/Bus sources.
// [R09] Other sources unscanned give zero auto delay.
// [R10] Scanning uses table delays for every source.
// [R11] Table delays for voltage, current, frequency.
// [R12] Resistance delays by range; RTD/thermistor follow.
// [R13] Thermocouple auto delay is one millisecond.
// [R14] Manual delay up to 99h 99m 99.999s.
// [R15] Auto key loads manual delay with 1 ms.
// [R16] Repeating filter takes count conversions, else one.
// [R17] Hold rejects out-of-window readings, restarts action.
// [R18] Relay transitions restart hold while scanning.
// [R19] Output trigger after each completed device action.
// [R20] Hold count 2 to 100 in window; the code uses i_hold_count as given, with no clamp to that range.
// [R21] Out-of-window reading reseeds and restarts count.
// [R22] Partner triggers with falling edge on line.
// [R23] Interlock low blocks all input triggers.
// [R24] Delay counts millisecond ticks; zero means no wait.
// [R25] Trigger line synchronised, one pulse per fall.
`include "mtseq_params.svh"
`timescale 1ns/100ps
`default_nettype none
module mtseq_core #(
   parameter int TICK_CYCLES = `MTSEQ_TICK_MS_CYCLES,
   parameter int OUT_PULSE_CYCLES = 10
)
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Trigger link and digital lines; the inputs are asynchronous, the output is registered.
   input wire logic i_ext_trig_n,
   input wire logic i_interlock,
   output logic o_measurement_complete_output,
   // Front panel and bus stimuli from core logic; one-cycle pulses except i_remote, which is a level.
   input wire logic i_trig_key,
   input wire logic i_bus_trig,
   input wire logic i_halt_cmd,
   input wire logic i_auto_key,
   input wire logic i_remote,
   // Trigger configuration.
   input wire logic i_continuous,
   input wire logic i_scanning,
   input wire mtseq_pkg::mtseq_src_t i_src,
   input wire logic i_auto_delay,
   input wire mtseq_pkg::mtseq_man_dly_t i_man_delay,
   input wire logic i_man_delay_load,
   input wire mtseq_pkg::mtseq_meas_cfg_t i_meas_cfg,
   // Device action configuration.
   input wire logic i_filter_repeat,
   input wire logic i_filter_full,
   input wire logic [6:0] i_filter_count,
   input wire logic i_hold_en,
   input wire logic [6:0] i_hold_count,
   input wire logic i_scan_last,
   // Converter handshake.
   output logic o_conv_start,
   output logic o_seed,
   input wire mtseq_pkg::mtseq_rdg_t i_rdg,
   // Relay handshake.
   output logic o_relay_step,
   input wire logic i_relay_done,
   // Status.
   output logic o_idle,
   output logic o_reading_accepted,
   output mtseq_pkg::mtseq_man_dly_t o_man_delay,
   output logic [2:0] o_state
);
   mtseq_pkg::mtseq_state_t state;
   mtseq_pkg::mtseq_state_t next_state;
   logic [2:0] trig_sync;
   logic [1:0] lock_sync;
   logic ext_pulse;
   logic event_hit;
   logic [31:0] tick_cnt;
   logic tick;
   logic [31:0] dly_ms;
   logic [6:0] conv_cnt;
   logic [6:0] hold_cnt;
   logic [7:0] out_cnt;
   logic scan_done;
   logic act_done;

   // Auto delay lookup in milliseconds; thermistor and RTD share the resistance column.
   function automatic logic [15:0] auto_ms(input mtseq_pkg::mtseq_meas_cfg_t c);
      logic [15:0] r;
      r = `MTSEQ_AD_1MS;
      unique case (c.func)
         mtseq_pkg::MTSEQ_F_DCV: r = (c.range >= `MTSEQ_DCV_HI_RANGE) ? `MTSEQ_AD_5MS : `MTSEQ_AD_1MS; // [R11]
         mtseq_pkg::MTSEQ_F_ACV, mtseq_pkg::MTSEQ_F_ACI: r = `MTSEQ_AD_400MS; // [R11]
         mtseq_pkg::MTSEQ_F_FREQ: r = `MTSEQ_AD_1MS; // [R11]
         mtseq_pkg::MTSEQ_F_DCI: r = `MTSEQ_AD_2MS; // [R11]
         mtseq_pkg::MTSEQ_F_TC: r = `MTSEQ_AD_1MS; // [R13]
         mtseq_pkg::MTSEQ_F_RES, mtseq_pkg::MTSEQ_F_RTEMP:
         begin
            unique case (c.range) // [R12]
               3'h0, 3'h1: r = `MTSEQ_AD_3MS;
               3'h2: r = `MTSEQ_AD_13MS;
               3'h3: r = `MTSEQ_AD_25MS;
               3'h4: r = `MTSEQ_AD_100MS;
               3'h5: r = `MTSEQ_AD_150MS;
               default: r = `MTSEQ_AD_250MS;
            endcase
         end
      endcase
      return r;
   endfunction

   // Total milliseconds of a manual setting, after clamping each field to its maximum.
   function automatic logic [31:0] man_ms(input mtseq_pkg::mtseq_man_dly_t d);
      logic [31:0] h;
      logic [31:0] m;
      logic [31:0] s;
      h = {25'h0, (d.hours > `MTSEQ_MAN_MAX_H) ? `MTSEQ_MAN_MAX_H : d.hours};
      m = {25'h0, (d.minutes > `MTSEQ_MAN_MAX_M) ? `MTSEQ_MAN_MAX_M : d.minutes};
      s = {15'h0, (d.millis > `MTSEQ_MAN_MAX_MS) ? `MTSEQ_MAN_MAX_MS : d.millis};
      return 32'(h * `MTSEQ_MS_PER_H + m * `MTSEQ_MS_PER_M + s); // [R14]
   endfunction

   // External trigger: two-flop synchroniser plus a third stage for the fall detector.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         trig_sync <= 3'h7;
         lock_sync <= 2'h3;
      end
      else
      begin
         trig_sync <= {trig_sync[1:0], i_ext_trig_n}; // [R25]
         lock_sync <= {lock_sync[0], i_interlock};
      end
   end

   // One pulse per falling edge, masked while the interlock holds the line low.
   assign ext_pulse = trig_sync[2] & ~trig_sync[1] & lock_sync[1]; // [R22] [R23] [R25]

   // Event detection; the key counts only in local, and the interlock gates every input trigger.
   always_comb
   begin
      event_hit = 1'b0;
      if (i_src == mtseq_pkg::MTSEQ_SRC_IMM)
         event_hit = 1'b1; // [R04]
      else if (i_src == mtseq_pkg::MTSEQ_SRC_EXT || i_src == mtseq_pkg::MTSEQ_SRC_BUS)
         event_hit = ext_pulse | (i_trig_key & ~i_remote & lock_sync[1]) | (i_bus_trig & lock_sync[1]); // [R05] [R06] [R23]
   end

   // Millisecond tick, free running so that a delay may start at any point of it.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         tick_cnt <= 32'h0;
      else if (tick_cnt == 32'(TICK_CYCLES - 1))
         tick_cnt <= 32'h0;
      else
         tick_cnt <= tick_cnt + 32'h1;
   end
   assign tick = (tick_cnt == 32'(TICK_CYCLES - 1)); // [R24]

   // Stored manual delay; the auto key overrides an entry in progress with one millisecond.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_man_delay <= '0;
      else if (i_auto_key)
         o_man_delay <= '{hours: 7'h00, minutes: 7'h00, millis: `MTSEQ_AUTO_KEY_MS}; // [R15]
      else if (i_man_delay_load)
         o_man_delay <= i_man_delay; // [R14]
   end

   // Delay countdown; a first partial tick makes the wait up to one tick short, a known limitation.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         dly_ms <= 32'h0;
      else if (state == mtseq_pkg::MTSEQ_S_EVENT && event_hit)
      begin
         if (!i_auto_delay)
            dly_ms <= man_ms(o_man_delay); // [R07]
         else if (i_scanning)
            dly_ms <= {16'h0, auto_ms(i_meas_cfg)}; // [R10]
         else if (i_src == mtseq_pkg::MTSEQ_SRC_EXT || i_src == mtseq_pkg::MTSEQ_SRC_BUS)
            dly_ms <= {16'h0, auto_ms(i_meas_cfg)}; // [R08]
         else
            dly_ms <= 32'h0; // [R09]
      end
      else if (state == mtseq_pkg::MTSEQ_S_DELAY && tick && dly_ms != 32'h0)
         dly_ms <= dly_ms - 32'h1; // [R24]
   end

   // A completed action while scanning with the last channel means the scan has ended.
   assign scan_done = i_scanning & i_scan_last;
   assign act_done = (state == mtseq_pkg::MTSEQ_S_WAIT) && i_rdg.valid
                     && (conv_cnt <= 7'h1 || !i_filter_repeat || i_filter_full)
                     && (!i_hold_en || (i_rdg.in_window && hold_cnt >= i_hold_count - 7'h1));

   // Sequencer state transitions.
   always_comb
   begin
      next_state = state;
      unique case (state)
         mtseq_pkg::MTSEQ_S_IDLE:
            if (i_scanning ? i_halt_cmd : (i_continuous || (i_trig_key && !i_remote))) // [R01] [R02] [R03] [R06]
               next_state = mtseq_pkg::MTSEQ_S_EVENT;
         mtseq_pkg::MTSEQ_S_EVENT:
            if (event_hit)
               next_state = mtseq_pkg::MTSEQ_S_DELAY; // [R07]
         mtseq_pkg::MTSEQ_S_DELAY:
            if (dly_ms == 32'h0)
               next_state = mtseq_pkg::MTSEQ_S_CONV; // [R24]
         mtseq_pkg::MTSEQ_S_CONV:
            next_state = mtseq_pkg::MTSEQ_S_WAIT;
         mtseq_pkg::MTSEQ_S_WAIT:
            if (i_rdg.valid)
            begin
               if (act_done)
                  next_state = i_scanning ? mtseq_pkg::MTSEQ_S_CHAN : mtseq_pkg::MTSEQ_S_OUT; // [R17]
               else
                  next_state = mtseq_pkg::MTSEQ_S_CONV; // [R16] [R17]
            end
         mtseq_pkg::MTSEQ_S_CHAN:
            if (i_relay_done)
               next_state = mtseq_pkg::MTSEQ_S_OUT; // [R18]
         mtseq_pkg::MTSEQ_S_OUT:
            if (out_cnt == 8'h1)
               next_state = (scan_done || (!i_scanning && !i_continuous)) ? mtseq_pkg::MTSEQ_S_IDLE
                                                                          : mtseq_pkg::MTSEQ_S_EVENT; // [R02] [R03]
         default:
            next_state = mtseq_pkg::MTSEQ_S_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state <= mtseq_pkg::MTSEQ_S_IDLE;
      else
         state <= next_state;
   end

   // Filter conversion counter: loaded on entry to the action, counts down per reading.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         conv_cnt <= 7'h0;
      else if (state == mtseq_pkg::MTSEQ_S_DELAY || state == mtseq_pkg::MTSEQ_S_CHAN)
         conv_cnt <= i_filter_repeat ? i_filter_count : 7'h1; // [R16]
      else if (state == mtseq_pkg::MTSEQ_S_WAIT && i_rdg.valid && conv_cnt > 7'h1)
         conv_cnt <= conv_cnt - 7'h1; // [R16]
   end

   // Hold counter: seed is reading zero, each in-window reading adds one, a miss reseeds.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         hold_cnt <= 7'h0;
      else if (state == mtseq_pkg::MTSEQ_S_DELAY || state == mtseq_pkg::MTSEQ_S_OUT)
         hold_cnt <= 7'h0;
      else if (state == mtseq_pkg::MTSEQ_S_CHAN && i_relay_done)
         hold_cnt <= 7'h0; // [R18]
      else if (state == mtseq_pkg::MTSEQ_S_WAIT && i_rdg.valid && i_hold_en
               && (conv_cnt <= 7'h1 || !i_filter_repeat || i_filter_full))
      begin
         if (hold_cnt == 7'h0 || i_rdg.in_window)
            hold_cnt <= hold_cnt + 7'h1; // [R20]
         else
            hold_cnt <= 7'h1; // [R21]
      end
   end

   // Converter start and seed flag, one cycle each.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_conv_start <= 1'b0;
         o_seed <= 1'b0;
      end
      else
      begin
         o_conv_start <= (next_state == mtseq_pkg::MTSEQ_S_CONV) && (state != mtseq_pkg::MTSEQ_S_CONV);
         o_seed <= (state == mtseq_pkg::MTSEQ_S_WAIT) && i_rdg.valid && i_hold_en
                   && hold_cnt != 7'h0 && !i_rdg.in_window; // [R21]
      end
   end

   // Relay step request; hold restarts after the relay finishes its transition.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_relay_step <= 1'b0;
      else
         o_relay_step <= (next_state == mtseq_pkg::MTSEQ_S_CHAN) && (state != mtseq_pkg::MTSEQ_S_CHAN); // [R18]
   end

   // Output trigger pulse length counter; the pulse stands a fixed number of cycles.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         out_cnt <= 8'h0;
      else if (next_state == mtseq_pkg::MTSEQ_S_OUT && state != mtseq_pkg::MTSEQ_S_OUT)
         out_cnt <= 8'(OUT_PULSE_CYCLES);
      else if (out_cnt != 8'h0)
         out_cnt <= out_cnt - 8'h1;
   end

   // Registered status and trigger outputs.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_measurement_complete_output <= 1'b0;
         o_reading_accepted <= 1'b0;
         o_idle <= 1'b1;
         o_state <= 3'h0;
      end
      else
      begin
         o_measurement_complete_output <= (next_state == mtseq_pkg::MTSEQ_S_OUT); // [R19]
         o_reading_accepted <= act_done; // [R17]
         o_idle <= (next_state == mtseq_pkg::MTSEQ_S_IDLE);
         o_state <= next_state;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/mtseq_params.svh ====
// Constants for the measurement trigger sequencer.
`ifndef MTSEQ_PARAMS_SVH
`define MTSEQ_PARAMS_SVH
`define MTSEQ_CLK_HZ 50000000
`define MTSEQ_TICK_MS_CYCLES (`MTSEQ_CLK_HZ / 1000)
`define MTSEQ_DLY_W 29
`define MTSEQ_DLY_MAX_MS 29 'd0
`define MTSEQ_AD_1MS 16'd1
`define MTSEQ_AD_2MS 16'd2
`define MTSEQ_AD_3MS 16'd3
`define MTSEQ_AD_5MS 16'd5
`define MTSEQ_AD_13MS 16'd13
`define MTSEQ_AD_25MS 16'd25
`define MTSEQ_AD_100MS 16'd100
`define MTSEQ_AD_150MS 16'd150
`define MTSEQ_AD_250MS 16'd250
`define MTSEQ_AD_400MS 16'd400
`define MTSEQ_DCV_HI_RANGE 3'h3
`define MTSEQ_HOLD_CNT_MIN 7'h02
`define MTSEQ_HOLD_CNT_MAX 7'h64
`define MTSEQ_MAN_MAX_H 7'h63
`define MTSEQ_MAN_MAX_M 7'h63
`define MTSEQ_MAN_MAX_MS 17'h1869F
`define MTSEQ_AUTO_KEY_MS 17'h00001
`define MTSEQ_MS_PER_S 32'd1000
`define MTSEQ_MS_PER_M 32'd60000
`define MTSEQ_MS_PER_H 32'd3600000
`define MTSEQ_OUT_PULSE_CYCLES 8'h0A
`endif

// ==== rtl/mtseq_pkg.sv ====
// Types for the measurement trigger sequencer.
package mtseq_pkg;
   typedef enum logic [2:0] {
      MTSEQ_F_DCV = 3'h0, MTSEQ_F_ACV = 3'h1, MTSEQ_F_FREQ = 3'h2, MTSEQ_F_DCI = 3'h3,
      MTSEQ_F_ACI = 3'h4, MTSEQ_F_RES = 3'h5, MTSEQ_F_TC = 3'h6, MTSEQ_F_RTEMP = 3'h7
   } mtseq_func_t;
   typedef enum logic [1:0] {
      MTSEQ_SRC_IMM = 2'h0, MTSEQ_SRC_EXT = 2'h1, MTSEQ_SRC_BUS = 2'h2, MTSEQ_SRC_OTHER = 2'h3
   } mtseq_src_t;
   typedef enum logic [2:0] {
      MTSEQ_S_IDLE = 3'h0, MTSEQ_S_EVENT = 3'h1, MTSEQ_S_DELAY = 3'h2, MTSEQ_S_CONV = 3'h3,
      MTSEQ_S_WAIT = 3'h4, MTSEQ_S_CHAN = 3'h5, MTSEQ_S_OUT = 3'h6
   } mtseq_state_t;
   // Manual delay as entered: hours, minutes and the seconds field in milliseconds.
   typedef struct packed {
      logic [6:0] hours;
      logic [6:0] minutes;
      logic [16:0] millis;
   } mtseq_man_dly_t;
   // Measurement setup that selects the auto delay.
   typedef struct packed {
      mtseq_func_t func;
      logic [2:0] range;
   } mtseq_meas_cfg_t;
   // One reading from the converter.
   typedef struct packed {
      logic valid;
      logic in_window;
   } mtseq_rdg_t;
endpackage

// ==== testbench/mtseq_link_partner.sv ====
// Trigger link partner model: fires the trigger line and times completion pulses.
`timescale 1ns/100ps
`default_nettype none
module mtseq_link_partner (
   // Clock and bench command.
   input wire logic i_core_clk,
   input wire logic i_fire,
   // Link lines.
   input wire logic i_complete,
   output logic o_trig_n,
   // Width of the last completion pulse in cycles.
   output var int o_width
);
   int run;
   // A fire request gives a five-cycle low pulse; the line idles high as if pulled up.
   initial
   begin
      o_trig_n = 1'b1;
      forever
      begin
         @(posedge i_core_clk);
         if (i_fire === 1'b1)
         begin
            #1 o_trig_n = 1'b0;
            repeat (5) @(posedge i_core_clk);
            #1 o_trig_n = 1'b1;
         end
      end
   end
   // Measures each completion pulse as the next instrument would see it.
   always @(posedge i_core_clk)
   begin
      run <= (i_complete === 1'b1) ? run + 1 : 0;
      if (i_complete !== 1'b1 && run > 0)
         o_width <= run;
   end
endmodule
`default_nettype wire

// ==== testbench/mtseq_sva.sv ====
// Port checker for the measurement trigger sequencer.
`timescale 1ns/100ps
`default_nettype none
module mtseq_sva #(
   parameter int OUT_PULSE_CYCLES = 10
)
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Stimuli and setup.
   input wire logic i_trig_key,
   input wire logic i_remote,
   input wire logic i_auto_key,
   input wire logic i_continuous,
   input wire logic i_scanning,
   input wire mtseq_pkg::mtseq_src_t i_src,
   input wire logic i_auto_delay,
   // Outputs.
   input wire logic o_measurement_complete_output,
   input wire logic o_conv_start,
   input wire logic o_relay_step,
   input wire mtseq_pkg::mtseq_man_dly_t o_man_delay,
   input wire logic [2:0] o_state
);
   logic [7:0] hi_cnt;
   logic idle;
   logic dly;
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   // State decodes keep the properties short.
   assign idle = o_state == mtseq_pkg::MTSEQ_S_IDLE;
   assign dly = o_state == mtseq_pkg::MTSEQ_S_DELAY;
   // Counts the running output pulse, since a repetition could not follow the parameter.
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         hi_cnt <= 8'h00;
      else
         hi_cnt <= o_measurement_complete_output ? hi_cnt + 8'h01 : 8'h00;
   end
   out_width_a: assert property ($fell(o_measurement_complete_output) |-> hi_cnt == 8'(OUT_PULSE_CYCLES))
      else $error("Output trigger width wrong.");
   cont_fall_a: assert property (idle && i_continuous && !i_scanning |=> o_state == mtseq_pkg::MTSEQ_S_EVENT)
      else $error("Continuous mode stayed idle.");
   shot_hold_a: assert property (idle && !i_continuous && !i_scanning && !(i_trig_key && !i_remote) |=> idle)
      else $error("One-shot left idle without a local key.");
   imm_event_a: assert property (o_state == mtseq_pkg::MTSEQ_S_EVENT && i_src == mtseq_pkg::MTSEQ_SRC_IMM |=> dly)
      else $error("Immediate source did not proceed.");
   conv_start_a: assert property (dly ##1 !dly |-> o_conv_start)
      else $error("No conversion after the delay.");
   zero_wait_a: assert property (dly && !i_auto_delay && o_man_delay == '0 |=> !dly)
      else $error("Zero manual delay waited.");
   auto_key_a: assert property (i_auto_key |=> o_man_delay == 31'h00000001)
      else $error("Auto key did not load one millisecond.");
   relay_scan_a: assert property (o_relay_step |-> i_scanning)
      else $error("Relay step outside scanning.");
   // Main flows seen by the run.
   cover property (idle ##1 !idle);
   cover property ($fell(o_measurement_complete_output));
   cover property (o_relay_step);
endmodule
bind mtseq_core mtseq_sva #(.OUT_PULSE_CYCLES(OUT_PULSE_CYCLES)) sva_i (.i_core_clk, .i_rst_n, .i_trig_key,
   .i_remote, .i_auto_key, .i_continuous, .i_scanning, .i_src, .i_auto_delay, .o_measurement_complete_output,
   .o_conv_start, .o_relay_step, .o_man_delay, .o_state);
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the measurement trigger sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int T = 4;
   // Design signals, counters and the auto delay table in milliseconds.
   logic i_core_clk, i_rst_n, i_interlock, i_trig_key, i_bus_trig, i_halt_cmd, i_auto_key, i_remote;
   logic i_continuous, i_scanning, i_auto_delay, i_man_delay_load, i_filter_repeat, i_filter_full;
   logic i_hold_en, i_scan_last, i_relay_done, fire, ext_n, cmp, conv, seed, step, idle, acc;
   logic [6:0] i_filter_count, i_hold_count;
   logic [2:0] st;
   mtseq_pkg::mtseq_src_t i_src;
   mtseq_pkg::mtseq_man_dly_t i_man_delay, man_q;
   mtseq_pkg::mtseq_meas_cfg_t i_meas_cfg;
   mtseq_pkg::mtseq_rdg_t i_rdg;
   int bad_count, samples_checked, width, n_conv, n_seed, n_acc, n_step;
   int tf[11] = '{0, 0, 1, 2, 3, 4, 5, 5, 5, 6, 7};
   int tr[11] = '{2, 3, 0, 4, 0, 3, 0, 2, 6, 0, 4};
   int tm[11] = '{1, 5, 400, 1, 2, 400, 3, 13, 250, 1, 100};
   bit win[$];
   mtseq_core #(.TICK_CYCLES(T)) dut (.i_core_clk, .i_rst_n, .i_ext_trig_n(ext_n), .i_interlock,
      .o_measurement_complete_output(cmp), .i_trig_key, .i_bus_trig, .i_halt_cmd, .i_auto_key, .i_remote,
      .i_continuous, .i_scanning, .i_src, .i_auto_delay, .i_man_delay, .i_man_delay_load, .i_meas_cfg,
      .i_filter_repeat, .i_filter_full, .i_filter_count, .i_hold_en, .i_hold_count, .i_scan_last,
      .o_conv_start(conv), .o_seed(seed), .i_rdg, .o_relay_step(step), .i_relay_done, .o_idle(idle),
      .o_reading_accepted(acc), .o_man_delay(man_q), .o_state(st));
   mtseq_link_partner lp (.i_core_clk, .i_fire(fire), .i_complete(cmp), .o_trig_n(ext_n), .o_width(width));
   // Bench helpers; every drive lands 1 ns after a rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      bad_count += int'(seen !== exp);
      if (seen !== exp)
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
   endtask
   task automatic wait_st(input logic [2:0] s, input int lim);
      for (int k = 0; k < lim && st !== s; k++)
         tick(1);
      chk(st, s, "state");
   endtask
   // Triggers one measurement by the chosen stimulus and times the delay stage.
   task automatic meas_dly(input int ms, input int k);
      int n;
      n = 0;
      wait_st(mtseq_pkg::MTSEQ_S_EVENT, 3000);
      if (k == 1)
         pulse(fire);
      if (k == 2)
         pulse(i_bus_trig);
      if (k == 3)
         pulse(i_trig_key);
      wait_st(mtseq_pkg::MTSEQ_S_DELAY, 20);
      for (n = 0; n < 5000 && st === mtseq_pkg::MTSEQ_S_DELAY; n++)
         tick(1);
      chk(n >= ms * T - T && n <= ms * T + 2, 1'b1, "delay cycles");
   endtask
   // A one-shot measurement started by a local key press.
   task automatic shot();
      {n_conv, n_seed, n_acc} = '0;
      pulse(i_trig_key);
      tick(2);
      chk(idle, 1'b0, "key starts");
      wait_st(mtseq_pkg::MTSEQ_S_IDLE, 800);
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Clock at 50 MHz.
   initial
   begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   // Converter answer: one valid reading two cycles after the start pulse is seen.
   task automatic conv_answer();
      tick(2);
      i_rdg = {1'b1, win.size() > 0 ? win.pop_front() : 1'b1};
      tick(1);
      i_rdg = 2'h0;
   endtask
   // Relay answer: settled two cycles after the step request is seen.
   task automatic relay_answer();
      tick(2);
      pulse(i_relay_done);
   endtask
   // Pulse counters and stand-ins; answers run in their own threads so that no edge goes unseen.
   always @(posedge i_core_clk)
   begin
      n_seed += int'(seed === 1'b1);
      n_acc += int'(acc === 1'b1);
      n_step += int'(step === 1'b1);
      n_conv += int'(conv === 1'b1);
      if (conv === 1'b1)
         fork
            conv_answer();
         join_none
      if (step === 1'b1)
         fork
            relay_answer();
         join_none
   end
   // Watchdog sized well above the longest delay table walk.
   initial
   begin
      repeat (60000) @(posedge i_core_clk);
      bad_count++;
      report_and_stop();
   end
   // Main sequence.
   initial
   begin
      {i_interlock, i_continuous, i_rdg, i_relay_done, i_filter_count, i_hold_count} = {4'hC, 1'b0, 14'h0183};
      {i_rst_n, i_trig_key, i_bus_trig, i_halt_cmd, i_auto_key, i_remote, i_scanning, i_auto_delay} = 8'h00;
      {i_man_delay_load, i_filter_repeat, i_filter_full, i_hold_en, i_scan_last, fire} = 6'h00;
      {i_src, i_man_delay, i_meas_cfg} = '0;
      tick(10);
      i_rst_n = 1'b1;
      tick(2);
      meas_dly(0, 0);
      tick(40);
      chk(width, 10, "trigger width");
      // The maximum setting is latched and checked, then the auto key replaces it with one millisecond before any delay uses it.
      i_auto_delay = 1'b1;
      i_man_delay = {7'h63, 7'h63, 17'h1869F};
      pulse(i_man_delay_load);
      chk(man_q, i_man_delay, "max delay");
      pulse(i_auto_key);
      chk(man_q, 31'h00000001, "auto key delay");
      i_auto_delay = 1'b0;
      meas_dly(1, 0);
      {i_src, i_interlock} = {mtseq_pkg::MTSEQ_SRC_EXT, 1'b0};
      wait_st(mtseq_pkg::MTSEQ_S_EVENT, 500);
      pulse(fire);
      pulse(i_bus_trig);
      tick(20);
      chk(st, mtseq_pkg::MTSEQ_S_EVENT, "blocked trigger");
      {i_interlock, i_auto_delay} = 2'h3;
      for (int i = 0; i < 11; i++)
      begin
         i_meas_cfg = {3'(tf[i]), 3'(tr[i])};
         meas_dly(tm[i], 1 + i % 3);
      end
      {i_src, i_meas_cfg} = {mtseq_pkg::MTSEQ_SRC_BUS, 6'h18};
      meas_dly(2, 2);
      {i_src, i_meas_cfg} = {mtseq_pkg::MTSEQ_SRC_IMM, 6'h2E};
      meas_dly(0, 0);
      {i_scanning, i_meas_cfg} = {1'b1, 6'h03};
      meas_dly(5, 0);
      i_scan_last = 1'b1;
      wait_st(mtseq_pkg::MTSEQ_S_IDLE, 3000);
      tick(30);
      chk(idle, 1'b1, "scan end idle");
      chk(n_step > 0, 1'b1, "relay steps");
      pulse(i_halt_cmd);
      tick(3);
      chk(idle, 1'b0, "halt resumes");
      {i_scanning, i_scan_last, i_continuous, i_auto_delay, i_remote} = 5'h01;
      wait_st(mtseq_pkg::MTSEQ_S_IDLE, 3000);
      pulse(i_trig_key);
      tick(5);
      chk(idle, 1'b1, "remote key");
      i_remote = 1'b0;
      i_filter_repeat = 1'b1;
      shot();
      chk(n_conv, 3, "filtered conversions");
      {i_filter_repeat, i_hold_en} = 2'h1;
      win = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      shot();
      chk(n_seed, 1, "reseeds");
      chk(n_acc, 1, "held readings");
      report_and_stop();
   end
endmodule
`default_nettype wire
